//--- hdl/fpmc_pkg.sv
package fpmc_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int unsigned ADDR_W = 18;
  localparam int unsigned DATA_W = 16;

  // ****************************************
  // Command codes and status bits
  // ****************************************
  localparam logic [7:0] CMD_READ_ARRAY  = 8'hff;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLR_STATUS  = 8'h50;
  localparam int unsigned STS_READY_BIT  = 7;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_PS    = 5000;
  localparam int unsigned PD_EXIT_DELAY_PS = 300000;
  localparam int unsigned PD_EXIT_CYC      = (PD_EXIT_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned PD_MIN_LOW_CYC   = 20;
  localparam int unsigned ACC_CYC          = 24;
  localparam int unsigned WR_CYC           = 16;
  localparam int unsigned GAP_CYC          = 4;
  localparam int unsigned CNT_W            = 8;

  // ****************************************
  // Request and answer carriers
  // ****************************************
  typedef enum logic [1:0] {
    FPMC_OP_READ   = 2'h0,
    FPMC_OP_WRITE  = 2'h1,
    FPMC_OP_STATUS = 2'h2
  } fpmc_op_t;

  typedef struct packed {
    fpmc_op_t            op;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   data;
  } fpmc_req_t;

  typedef struct packed {
    logic [DATA_W-1:0]   data;
    logic                ready_bit;
  } fpmc_rsp_t;

  typedef enum logic [5:0] {
    ST_POWERDOWN = 6'h01,
    ST_RECOVER   = 6'h02,
    ST_IDLE      = 6'h04,
    ST_READ      = 6'h08,
    ST_WRITE     = 6'h10,
    ST_GAP       = 6'h20
  } fpmc_state_t;

endpackage : fpmc_pkg

//--- hdl/fpmc_host.sv
`timescale 1ns/1ps
`default_nettype none
module fpmc_host
  import fpmc_pkg::*;
#(
  parameter int unsigned PD_EXIT_CYCLES = PD_EXIT_CYC
) (
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  input  wire logic              req_valid,
  input  wire fpmc_req_t         req,
  input  wire logic              powerdown_req,
  input  wire logic              supply_low,
  output logic                   req_ready,
  output logic                   rsp_valid,
  output fpmc_rsp_t              rsp,
  output logic                   busy_seen,
  output logic                   reset_powerdown_pin_n,
  output logic                   chip_sel_n,
  output logic                   out_en_n,
  output logic                   wr_strobe_n,
  output logic [ADDR_W-1:0]      addr_out,
  output logic [DATA_W-1:0]      dq_out,
  output logic                   dq_oe_n,
  input  wire logic [DATA_W-1:0] dq_in
);

  // ****************************************
  // Pin input synchronisers
  // ****************************************
  logic [DATA_W-1:0] dq_s1_q;
  logic [DATA_W-1:0] dq_s2_q;
  logic [1:0]        pd_s_q;
  logic [1:0]        lo_s_q;

  always_ff @(posedge clk_sys) begin
    dq_s1_q <= dq_in;
    dq_s2_q <= dq_s1_q;
    pd_s_q  <= {pd_s_q[0], powerdown_req};
    lo_s_q  <= {lo_s_q[0], supply_low};
  end

  logic hold_down;
  assign hold_down = pd_s_q[1] | lo_s_q[1];

  // ****************************************
  // Sequencer
  // ****************************************
  fpmc_state_t       st_q, st_d;
  logic [CNT_W+4:0]  cnt_q, cnt_d;
  fpmc_op_t          op_q, op_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [DATA_W-1:0] wdat_q, wdat_d;
  logic              rp_n_q, rp_n_d;
  logic              ce_n_q, ce_n_d;
  logic              oe_n_q, oe_n_d;
  logic              we_n_q, we_n_d;
  logic              doe_n_q, doe_n_d;
  logic              rdy_q, rdy_d;
  logic              rv_q, rv_d;
  fpmc_rsp_t         rsp_q, rsp_d;
  logic              busy_q, busy_d;

  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    op_d    = op_q;
    addr_d  = addr_q;
    wdat_d  = wdat_q;
    rp_n_d  = rp_n_q;
    ce_n_d  = ce_n_q;
    oe_n_d  = oe_n_q;
    we_n_d  = we_n_q;
    doe_n_d = doe_n_q;
    rdy_d   = 1'b0;
    rv_d    = 1'b0;
    rsp_d   = rsp_q;
    busy_d  = busy_q;
    unique case (st_q)
      ST_POWERDOWN: begin
        // Device is off and ignores controls, so park them idle
        rp_n_d  = 1'b0;
        ce_n_d  = 1'b1;
        oe_n_d  = 1'b1;
        we_n_d  = 1'b1;
        doe_n_d = 1'b1;
        cnt_d   = cnt_q + 1'b1;
        if (!hold_down && cnt_q >= (CNT_W+5)'(PD_MIN_LOW_CYC)) begin
          rp_n_d = 1'b1;
          cnt_d  = '0;
          st_d   = ST_RECOVER;
        end
      end
      ST_RECOVER: begin
        // Device comes back in array-read mode after the exit delay
        cnt_d = cnt_q + 1'b1;
        if (hold_down) begin
          cnt_d = '0;
          st_d  = ST_POWERDOWN;
        end else if (cnt_q >= (CNT_W+5)'(PD_EXIT_CYCLES - 1)) begin
          cnt_d  = '0;
          busy_d = 1'b0;
          st_d   = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (hold_down) begin
          cnt_d = '0;
          st_d  = ST_POWERDOWN;
        end else if (req_valid) begin
          rdy_d  = 1'b1;
          op_d   = req.op;
          addr_d = req.addr;
          wdat_d = req.data;
          cnt_d  = '0;
          ce_n_d = 1'b0;
          if (req.op == FPMC_OP_WRITE) begin
            we_n_d  = 1'b0;
            doe_n_d = 1'b0;
            st_d    = ST_WRITE;
          end else begin
            oe_n_d = 1'b0;
            st_d   = ST_READ;
          end
        end
      end
      ST_READ: begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_q >= (CNT_W+5)'(ACC_CYC - 1)) begin
          rv_d            = 1'b1;
          rsp_d.data      = dq_s2_q;
          rsp_d.ready_bit = dq_s2_q[STS_READY_BIT];
          if (op_q == FPMC_OP_STATUS)
            busy_d = ~dq_s2_q[STS_READY_BIT];
          ce_n_d = 1'b1;
          oe_n_d = 1'b1;
          cnt_d  = '0;
          st_d   = ST_GAP;
        end
      end
      ST_WRITE: begin
        // Data path holds each command; only a 0x40 setup needs a second write
        cnt_d = cnt_q + 1'b1;
        if (cnt_q >= (CNT_W+5)'(WR_CYC - 1)) begin
          we_n_d = 1'b1;
          cnt_d  = '0;
          st_d   = ST_GAP;
        end
      end
      ST_GAP: begin
        ce_n_d  = 1'b1;
        doe_n_d = 1'b1;
        cnt_d   = cnt_q + 1'b1;
        if (cnt_q >= (CNT_W+5)'(GAP_CYC - 1)) begin
          cnt_d = '0;
          st_d  = ST_IDLE;
        end
      end
      default: begin
        cnt_d = '0;
        st_d  = ST_POWERDOWN;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_q    <= ST_POWERDOWN;
      cnt_q   <= '0;
      op_q    <= FPMC_OP_READ;
      addr_q  <= '0;
      wdat_q  <= '0;
      rp_n_q  <= 1'b0;
      ce_n_q  <= 1'b1;
      oe_n_q  <= 1'b1;
      we_n_q  <= 1'b1;
      doe_n_q <= 1'b1;
      rdy_q   <= 1'b0;
      rv_q    <= 1'b0;
      rsp_q   <= '0;
      busy_q  <= 1'b0;
    end else begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      op_q    <= op_d;
      addr_q  <= addr_d;
      wdat_q  <= wdat_d;
      rp_n_q  <= rp_n_d;
      ce_n_q  <= ce_n_d;
      oe_n_q  <= oe_n_d;
      we_n_q  <= we_n_d;
      doe_n_q <= doe_n_d;
      rdy_q   <= rdy_d;
      rv_q    <= rv_d;
      rsp_q   <= rsp_d;
      busy_q  <= busy_d;
    end
  end

  assign req_ready             = rdy_q;
  assign rsp_valid             = rv_q;
  assign rsp                   = rsp_q;
  assign busy_seen             = busy_q;
  assign reset_powerdown_pin_n = rp_n_q;
  assign chip_sel_n            = ce_n_q;
  assign out_en_n              = oe_n_q;
  assign wr_strobe_n           = we_n_q;
  assign addr_out              = addr_q;
  assign dq_out                = wdat_q;
  assign dq_oe_n               = doe_n_q;

endmodule : fpmc_host
`default_nettype wire

//--- testbench/fpmc_chk.sv
`timescale 1ns/1ps
`default_nettype none
module fpmc_chk
  import fpmc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic powerdown_req,
  input wire logic supply_low,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic reset_powerdown_pin_n,
  input wire logic chip_sel_n,
  input wire logic out_en_n,
  input wire logic wr_strobe_n,
  input wire logic dq_oe_n
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // Cycles since the reset pin went high, saturating
  localparam logic [7:0] EXIT_LIM = 8'(PD_EXIT_CYC);
  logic [7:0] wake_q;
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !reset_powerdown_pin_n) wake_q <= 8'h00;
    else if (wake_q != 8'hff) wake_q <= wake_q + 8'h01;
  end
  sequence s_wr_low;
    !wr_strobe_n [*8] ##1 !wr_strobe_n [*8];
  endsequence
  sequence s_rd_low;
    (!chip_sel_n && !out_en_n) [*8];
  endsequence
  property p_wr_len;
    $fell(wr_strobe_n) |-> s_wr_low ##1 wr_strobe_n;
  endproperty
  property p_rd_ans;
    $fell(out_en_n) |-> s_rd_low ##17 (rsp_valid && chip_sel_n);
  endproperty
  property p_wr_sel;
    !wr_strobe_n |-> !chip_sel_n;
  endproperty
  property p_wr_end;
    $rose(wr_strobe_n) |=> $rose(chip_sel_n);
  endproperty
  property p_pd_quiet;
    !reset_powerdown_pin_n |-> chip_sel_n && out_en_n && wr_strobe_n;
  endproperty
  property p_recover;
    reset_powerdown_pin_n && wake_q < EXIT_LIM |-> chip_sel_n;
  endproperty
  property p_ready_cs;
    req_ready |-> !chip_sel_n;
  endproperty
  property p_dq;
    !dq_oe_n |-> out_en_n;
  endproperty
  property p_pd_in;
    $rose(powerdown_req || supply_low) |-> ##[1:40] !reset_powerdown_pin_n;
  endproperty
  a_wr_len: assert property (p_wr_len) else $error("strobe width wrong");
  a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
  a_wr_sel: assert property (p_wr_sel) else $error("strobe without select");
  a_wr_end: assert property (p_wr_end) else $error("select not released");
  a_pd_quiet: assert property (p_pd_quiet) else $error("active in power-down");
  a_recover: assert property (p_recover) else $error("access too early");
  a_ready_cs: assert property (p_ready_cs) else $error("taken without select");
  a_dq: assert property (p_dq) else $error("data bus contention");
  a_pd_in: assert property (p_pd_in) else $error("no power-down");
endmodule : fpmc_chk
bind fpmc_host fpmc_chk i_fpmc_chk (.*);
`default_nettype wire

//--- testbench/fpmc_dev.sv
`timescale 1ns/1ps
`default_nettype none
module fpmc_dev
  import fpmc_pkg::*;
(
  input wire logic              clk_sys,
  input wire logic              reset_powerdown_pin_n,
  input wire logic              chip_sel_n,
  input wire logic              out_en_n,
  input wire logic              wr_strobe_n,
  input wire logic [ADDR_W-1:0] addr_out,
  input wire logic [DATA_W-1:0] dq_out,
  output logic [DATA_W-1:0]     dq_in = 16'h0000
);
  logic [DATA_W-1:0] mem [int];
  logic [7:0]        mode = CMD_READ_ARRAY;
  logic              setup = 1'b0;
  logic              we_p = 1'b1;
  int                busy = 0;
  int                wake = 0;
  always @(posedge clk_sys) begin
    we_p <= wr_strobe_n;
    if (!reset_powerdown_pin_n) wake <= PD_EXIT_CYC;
    else if (wake > 0) wake <= wake - 1;
    if (!reset_powerdown_pin_n) begin
      mode <= CMD_READ_ARRAY;
      setup <= 1'b0;
      busy <= 0;
    end else begin
      if (busy > 0) busy <= busy - 1;
      if (wr_strobe_n && !we_p && !chip_sel_n) begin
        if (setup) begin
          mem[addr_out] = dq_out & (mem.exists(addr_out) ? mem[addr_out] : 16'hffff);
          busy <= 200;
          mode <= CMD_READ_STATUS;
        end else mode <= dq_out[7:0];
        setup <= !setup && dq_out[7:0] == 8'h40;
      end
    end
    // Released bus toggles so a stale value never passes
    if (!reset_powerdown_pin_n || wake > 0 || chip_sel_n || out_en_n) dq_in <= ~dq_in;
    else if (mode == CMD_READ_STATUS) dq_in <= {8'h00, busy == 0, 7'h00};
    else dq_in <= mem.exists(addr_out) ? mem[addr_out] : 16'hffff;
  end
endmodule : fpmc_dev
`default_nettype wire

//--- testbench/fpmc_host_bench.sv
`timescale 1ns/1ps
`default_nettype none
module fpmc_host_bench;
  import fpmc_pkg::*;
  logic              clk_sys = 1'b0;
  logic              sys_rst = 1'b1;
  logic              req_valid = 1'b0;
  fpmc_req_t         req = '0;
  logic [1:0]        hold = 2'b00;
  wire               powerdown_req = hold[0];
  wire               supply_low = hold[1];
  logic              req_ready, rsp_valid, busy_seen, reset_powerdown_pin_n;
  logic              chip_sel_n, out_en_n, wr_strobe_n, dq_oe_n;
  fpmc_rsp_t         rsp;
  logic [ADDR_W-1:0] addr_out;
  logic [DATA_W-1:0] dq_out, dq_in;
  int                error_cnt = 0;
  int                compares = 0;
  int                seed = 67;
  int                mem_m [int];
  int                a, d;
  always #2.5 clk_sys = ~clk_sys;
  fpmc_host i_fpmc_host (.*);
  fpmc_dev i_fpmc_dev (.*);
  task automatic results();
    if (error_cnt == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic wt(input bit rd);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while ((rd ? rsp_valid : req_ready) !== 1'b1 && n < 500);
    if ((rd ? rsp_valid : req_ready) !== 1'b1) begin
      error_cnt++;
      results();
    end
  endtask : wt
  task automatic op(input fpmc_op_t o, input int ad, input int da);
    req <= '{o, ad[ADDR_W-1:0], da[DATA_W-1:0]};
    req_valid <= 1'b1;
    wt(1'b0);
    req_valid <= 1'b0;
    if (o != FPMC_OP_WRITE) wt(1'b1);
    else @(posedge clk_sys);
  endtask : op
  initial begin
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    a = $random(seed) & 32'h3ffff;
    d = $random(seed) & 32'hffff;
    op(FPMC_OP_READ, a, 0);
    chk("blank", rsp.data, 16'hffff);
    op(FPMC_OP_WRITE, a, 32'h40);
    op(FPMC_OP_WRITE, a, d);
    mem_m[a] = d;
    op(FPMC_OP_STATUS, a, 0);
    chk("busy", {rsp.ready_bit, busy_seen}, 2'b01);
    for (int i = 0; i < 20 && rsp.ready_bit !== 1'b1; i++) op(FPMC_OP_STATUS, a, 0);
    chk("done", rsp.ready_bit, 1'b1);
    op(FPMC_OP_WRITE, a, CMD_READ_ARRAY);
    op(FPMC_OP_READ, a, 0);
    chk("prog", rsp.data, mem_m[a]);
    op(FPMC_OP_WRITE, a, 32'h0);
    op(FPMC_OP_READ, a, 0);
    chk("single", rsp.data, mem_m[a]);
    for (int k = 0; k < 2; k++) begin
      op(FPMC_OP_WRITE, a, CMD_READ_STATUS);
      hold[k] <= 1'b1;
      repeat (30) @(posedge clk_sys);
      chk("pins", {reset_powerdown_pin_n, chip_sel_n}, 2'b01);
      hold[k] <= 1'b0;
      op(FPMC_OP_READ, a, 0);
      chk("exit", rsp.data, mem_m[a]);
    end
    // System reset in mid-write must pull the reset pin and boot in array mode
    op(FPMC_OP_WRITE, a, CMD_READ_STATUS);
    sys_rst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk("rst", reset_powerdown_pin_n, 1'b0);
    sys_rst <= 1'b0;
    op(FPMC_OP_READ, a, 0);
    chk("boot", rsp.data, mem_m[a]);
    results();
  end
endmodule : fpmc_host_bench
`default_nettype wire
